/* File: pgp_far_side.sv */
// pgp_far_side: outside circuitry on the port 3 pins
// assumes the bench says which undriven lines are held from outside
`timescale 1ns/1ps
`default_nettype none
module pgp_far_side (
   input  wire logic        clk,
   input  wire logic [15:0] pin_o,
   input  wire logic [15:0] pin_oe,
   input  wire logic [15:0] ext_en,
   input  wire logic [15:0] ext_val,
   output logic      [15:0] pin_i
);
   logic [15:0] last_q = 16'h0000;
   // outside drives only released lines; a floating line flips so no stale level passes
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & ~last_q)));
   always @(posedge clk) last_q <= pin_i;
endmodule
`default_nettype wire

/* File: pgp_pin_mux.sv */
// pgp_pin_mux: per-line output value and driver enable
// assumes the alternate outputs rest high when their peripheral is idle
`timescale 1ns/1ps
`default_nettype none
module pgp_pin_mux (
   input  wire logic [15:0] latch,
   input  wire logic [15:0] dir,
   input  wire logic [15:0] odrain,
   input  wire logic [15:0] alt_out,
   input  wire logic [15:0] alt_oe,
   output logic      [15:0] pin_o,
   output logic      [15:0] pin_oe
);
   import pgp_pkg::*;
   wire [15:0] level;
   wire [15:0] drive;
   assign level  = latch & alt_out;                       // [RL5] [RL7]
   assign drive  = (dir | alt_oe) & PGP_MASK_PINS;         // [RL1] [RL3] [RL19]
   // open-drain lines release the pin on a high level instead of driving it
   assign pin_o  = level;
   assign pin_oe = drive & ~(odrain & level);              // [RL2] [RL20]
endmodule
`default_nettype wire

/* File: pgp_pkg.sv */
// pgp_pkg: register map, field layout and reset values of the port 3 block
// assumes word-aligned 32-bit AHB-Lite access, registers in the low half-word
package pgp_pkg;
   localparam logic [15:0] PGP_ADDR_OPEN_DRAIN = 16'hF1C6;
   localparam logic [15:0] PGP_ADDR_DATA       = 16'hFFC4;
   localparam logic [15:0] PGP_ADDR_DIRECTION  = 16'hFFC6;
   // printed offsets are not all word multiples: byte address is four times the index
   localparam logic [17:0] PGP_BYTE_OPEN_DRAIN = {PGP_ADDR_OPEN_DRAIN, 2'b00};
   localparam logic [17:0] PGP_BYTE_DATA       = {PGP_ADDR_DATA, 2'b00};
   localparam logic [17:0] PGP_BYTE_DIRECTION  = {PGP_ADDR_DIRECTION, 2'b00};
   localparam logic [17:0] PGP_BYTE_STRAP      = 18'h3FF00;
   localparam logic [15:0] PGP_RST_DATA        = 16'h0000;
   localparam logic [15:0] PGP_RST_DIRECTION   = 16'h0000;
   localparam logic [15:0] PGP_RST_OPEN_DRAIN  = 16'h0000;
   localparam logic [15:0] PGP_MASK_DATA       = 16'hFFFF;
   localparam logic [15:0] PGP_MASK_DIRECTION  = 16'hBFFF;
   localparam logic [15:0] PGP_MASK_OPEN_DRAIN = 16'h2FFF;
   localparam logic [15:0] PGP_MASK_PINS       = 16'hBFFF;
   localparam int          PGP_BIT_TIMER6_TOGGLE_OUT       = 1;
   localparam int          PGP_BIT_TIMER3_TOGGLE_OUT       = 3;
   localparam int          PGP_BIT_SYNC_MASTER_RX_SLAVE_TX        = 8;
   localparam int          PGP_BIT_SYNC_MASTER_TX_SLAVE_RX        = 9;
   localparam int          PGP_BIT_TXD         = 10;
   localparam int          PGP_BIT_RXD         = 11;
   localparam int          PGP_BIT_STROBE      = 12;
   localparam int          PGP_BIT_SCLK        = 13;
   localparam int          PGP_BIT_SYSTEM_CLOCK_OUT      = 15;
   localparam logic [1:0]  PGP_HTRANS_NONSEQ   = 2'b10;
   typedef enum logic [2:0] {
      PGP_IDLE  = 3'b001,
      PGP_WRITE = 3'b010,
      PGP_READ  = 3'b100
   } pgp_phase_e;
endpackage

/* File: pgp_port3.sv */
// pgp_port3: port 3 gpio with alternate functions, AHB-Lite register slave
// assumes a single AHB-Lite master, word transfers, synchronous pin inputs
// Operation
// [RL1] fifteen usable lines, each with its own direction bit
// [RL2] push-pull or open-drain per line, except lines 15, 14, 12
// [RL3] latch bit 14 exists but drives no pin
// [RL4] alternate inputs receive the sampled pin state
// [RL5] alternate output pin value is peripheral output ANDed with latch
// [RL6] software sets direction output and latch one for alternate outputs
// [RL7] idle alternate outputs rest high so latch alone decides
// [RL8] bidirectional alternate lines follow peripheral mode and software direction
// [RL9] clock output enables line 15 driver automatically
// [RL10] strobe on line 12 selected automatically after reset from strap
// [RL11] line 12 becomes gpio when strobe disabled by strap bits
// [RL12] strobe function enables line 12 driver regardless of direction
// [RL13] during bus hold line 12 returns to plain port function
// [RL14] software keeps line 12 direction zero so it floats in hold
// [RL15] timer 6, timer 3 toggles on lines 1, 3; async transmit line 10
// [RL16] lines 0,2,4,5,6,7 feed timer count, capture, up/down inputs
// [RL17] line 11 receives async data, drives it in synchronous mode
// [RL18] lines 8, 9, 13 carry sync serial data and shift clock
// [RL19] direction zero means input; all control bits clear at reset
// [RL20] open-drain bit one selects open drain; missing bits read zero
`timescale 1ns/1ps
`default_nettype none
module pgp_port3 (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [15:0] pin_i,
   output logic      [15:0] pin_o,
   output logic      [15:0] pin_oe,
   input  wire logic        timer6_toggle_out,
   input  wire logic        timer3_toggle_out,
   input  wire logic        async_serial_tx,
   input  wire logic        async_serial_rx_out,
   input  wire logic        async_serial_rx_oe,
   input  wire logic        sync_master_rx_slave_tx,
   input  wire logic        sync_master_tx_slave_rx,
   input  wire logic        sync_clock_out,
   input  wire logic        high_byte_write_strobe,
   input  wire logic        system_clock_out,
   input  wire logic        system_clock_out_en,
   input  wire logic        byte_strobe_disable,
   input  wire logic        write_strobe_config,
   input  wire logic        bus_hold,
   output logic             compare_timer0_count_in,
   output logic             capture_in,
   output logic             timer3_updown_in,
   output logic             timer4_count_in,
   output logic             timer3_count_in,
   output logic             timer2_count_in,
   output logic             async_serial_rx,
   output logic             sync_master_rx_slave_tx_in,
   output logic             sync_master_tx_slave_rx_in,
   output logic             sync_clock_in
);
   import pgp_pkg::*;

   logic [15:0] data_q;
   logic [15:0] dir_q;
   logic [15:0] od_q;
   logic [15:0] in_q;
   logic [17:0] addr_q;
   logic [31:0] rdata_q;
   pgp_phase_e  phase_q;
   logic        strobe_sel;

   function automatic logic [15:0] pgp_rd(input logic [17:0] a, input logic [15:0] d,
                                          input logic [15:0] r, input logic [15:0] o,
                                          input logic [15:0] i);
      logic [15:0] v;
      v = 16'h0000;
      if (a == PGP_BYTE_DATA) v = d;
      if (a == PGP_BYTE_DIRECTION) v = r;
      if (a == PGP_BYTE_OPEN_DRAIN) v = o;
      if (a == PGP_BYTE_STRAP) v = i;
      return v;
   endfunction

   wire        take     = hsel & hready & (htrans == PGP_HTRANS_NONSEQ);
   wire [17:0] word_adr = {haddr[17:2], 2'b00};
   wire        wr_data  = (phase_q == PGP_WRITE) && (addr_q == PGP_BYTE_DATA);
   wire        wr_dir   = (phase_q == PGP_WRITE) && (addr_q == PGP_BYTE_DIRECTION);
   wire        wr_od    = (phase_q == PGP_WRITE) && (addr_q == PGP_BYTE_OPEN_DRAIN);
   // at the data address the read path returns the pin input latch for input lines and the data latch for output lines
   wire [15:0] rd_pins  = (in_q & ~dir_q) | (data_q & dir_q);
   wire [15:0] status   = {15'h0000, strobe_sel};
   wire [15:0] rd_val   = (word_adr == PGP_BYTE_DATA) ? rd_pins :
                          pgp_rd(word_adr, data_q, dir_q, od_q, status);

   // registers answer with zero wait states and always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_q <= PGP_IDLE;
         addr_q  <= 18'h00000;
         rdata_q <= 32'h00000000;
      end else begin
         phase_q <= take ? (hwrite ? PGP_WRITE : PGP_READ) : PGP_IDLE;
         if (take) begin
            addr_q  <= word_adr;
            rdata_q <= hwrite ? rdata_q : {16'h0000, rd_val};
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_q <= PGP_RST_DATA;                                   // [RL19]
         dir_q  <= PGP_RST_DIRECTION;
         od_q   <= PGP_RST_OPEN_DRAIN;
         in_q   <= 16'h0000;
      end else begin
         in_q <= pin_i;                                            // [RL4]
         if (wr_data) data_q <= hwdata[15:0] & PGP_MASK_DATA;      // [RL3]
         if (wr_dir)  dir_q  <= hwdata[15:0] & PGP_MASK_DIRECTION; // [RL1]
         if (wr_od)   od_q   <= hwdata[15:0] & PGP_MASK_OPEN_DRAIN; // [RL2] [RL20]
      end
   end

   pgp_strap u_strap (
      .clk                 (clk),
      .sys_rst             (sys_rst),
      .byte_strobe_disable (byte_strobe_disable),
      .write_strobe_config (write_strobe_config),
      .bus_hold            (bus_hold),
      .strobe_sel          (strobe_sel)
   );

   logic [15:0] alt_out;
   logic [15:0] alt_oe;
   always_comb begin
      alt_out = 16'hFFFF;                                          // [RL7]
      alt_oe  = 16'h0000;
      alt_out[PGP_BIT_TIMER6_TOGGLE_OUT]  = timer6_toggle_out;                 // [RL15]
      alt_out[PGP_BIT_TIMER3_TOGGLE_OUT]  = timer3_toggle_out;
      alt_out[PGP_BIT_TXD]    = async_serial_tx;
      alt_out[PGP_BIT_SYNC_MASTER_RX_SLAVE_TX]   = sync_master_rx_slave_tx;           // [RL18] [RL8]
      alt_out[PGP_BIT_SYNC_MASTER_TX_SLAVE_RX]   = sync_master_tx_slave_rx;
      alt_out[PGP_BIT_SCLK]   = sync_clock_out;
      alt_out[PGP_BIT_RXD]    = async_serial_rx_out;               // [RL17]
      alt_oe[PGP_BIT_RXD]     = async_serial_rx_oe;
      // strobe bypasses the latch: nothing can program it before first bus cycle
      alt_out[PGP_BIT_STROBE] = strobe_sel ? high_byte_write_strobe : 1'b1;
      alt_oe[PGP_BIT_STROBE]  = strobe_sel;                        // [RL12]
      alt_out[PGP_BIT_SYSTEM_CLOCK_OUT] = system_clock_out_en ? system_clock_out : 1'b1;
      alt_oe[PGP_BIT_SYSTEM_CLOCK_OUT]  = system_clock_out_en;               // [RL9]
   end

   // strobe and clock functions force their latch bit high so the peripheral alone decides
   wire [15:0] eff_latch = strobe_sel ? (data_q | 16'h1000) : data_q;
   wire [15:0] eff_latch2 = system_clock_out_en ? (eff_latch | 16'h8000) : eff_latch;

   pgp_pin_mux u_mux (
      .latch   (eff_latch2),
      .dir     (dir_q),
      .odrain  (od_q),
      .alt_out (alt_out),
      .alt_oe  (alt_oe),
      .pin_o   (pin_o),
      .pin_oe  (pin_oe)
   );

   // alternate inputs see the input latch, never the raw pin
   assign compare_timer0_count_in    = in_q[0];                    // [RL16] [RL4]
   assign capture_in                 = in_q[2];
   assign timer3_updown_in           = in_q[4];
   assign timer4_count_in            = in_q[5];
   assign timer3_count_in            = in_q[6];
   assign timer2_count_in            = in_q[7];
   assign sync_master_rx_slave_tx_in = in_q[PGP_BIT_SYNC_MASTER_RX_SLAVE_TX];         // [RL8]
   assign sync_master_tx_slave_rx_in = in_q[PGP_BIT_SYNC_MASTER_TX_SLAVE_RX];
   assign async_serial_rx            = in_q[PGP_BIT_RXD];
   assign sync_clock_in              = in_q[PGP_BIT_SCLK];
endmodule
`default_nettype wire

/* File: pgp_port3_asserts.sv */
// pgp_port3_chk: bus and pin relations of pgp_port3
// assumes one clock, sys_rst asynchronous and active high
`timescale 1ns/1ps
`default_nettype none
module pgp_port3_chk
   import pgp_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [15:0] pin_i,
   input wire logic [15:0] pin_o,
   input wire logic [15:0] pin_oe,
   input wire logic        timer6_toggle_out,
   input wire logic        high_byte_write_strobe,
   input wire logic        system_clock_out,
   input wire logic        system_clock_out_en,
   input wire logic        async_serial_rx_oe,
   input wire logic        byte_strobe_disable,
   input wire logic        write_strobe_config,
   input wire logic        bus_hold,
   input wire logic        compare_timer0_count_in
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   wire sel_in = (!byte_strobe_disable || write_strobe_config) && !bus_hold;
   wire rd_req = hsel && hready && htrans == PGP_HTRANS_NONSEQ && !hwrite;
   sequence rd_at(logic [17:0] a);
      rd_req && haddr[17:0] == a;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_pin14_quiet: assert property (!pin_oe[14])
      else $error("line 14 driven");
   a_alt_in_latch: assert property (!$past(sys_rst) |->
      compare_timer0_count_in == $past(pin_i[0])) else $error("count input not latched pin");
   a_toggle_and: assert property (!timer6_toggle_out |-> !pin_o[1])
      else $error("toggle output not gated");
   a_clock_drive: assert property (system_clock_out_en |->
      pin_oe[15] && pin_o[15] == system_clock_out) else $error("clock line not driven");
   a_strobe_drive: assert property (!$past(sys_rst) && $past(sel_in) && sel_in |->
      pin_oe[12] && pin_o[12] == high_byte_write_strobe) else $error("strobe line wrong");
   a_dir_read: assert property (rd_at(PGP_BYTE_DIRECTION) |=>
      hrdata[31:16] == 16'h0000 && !hrdata[14]) else $error("direction read bits set");
   a_od_read: assert property (rd_at(PGP_BYTE_OPEN_DRAIN) |=>
      (hrdata & 32'hFFFF_D000) == 32'h0000_0000) else $error("open drain read bits set");
   a_rdata_hold: assert property (!rd_req |=> $stable(hrdata))
      else $error("read data moved without read");
   a_rx_drive: assert property (async_serial_rx_oe && !pin_o[11] |-> pin_oe[11])
      else $error("receive line not driven in synchronous mode");
endmodule
bind pgp_port3 pgp_port3_chk i_chk (.*);
`default_nettype wire

/* File: pgp_strap.sv */
// pgp_strap: strobe selection on line 12 resampled every clock after reset release
// assumes the strap inputs are stable around reset
`timescale 1ns/1ps
`default_nettype none
module pgp_strap (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic byte_strobe_disable,
   input  wire logic write_strobe_config,
   input  wire logic bus_hold,
   output logic      strobe_sel
);
   logic caught_q;
   logic enable_q;
   // the strap is sampled by a clocked process after release, not by the reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         caught_q <= 1'b0;
         enable_q <= 1'b0;
      end else if (!caught_q) begin
         caught_q <= 1'b1;
         enable_q <= ~byte_strobe_disable | write_strobe_config;   // [RL10]
      end else begin
         enable_q <= ~byte_strobe_disable | write_strobe_config;   // [RL11]
      end
   end
   assign strobe_sel = enable_q & ~bus_hold;                       // [RL13]
endmodule
`default_nettype wire

/* File: pgp_tb.sv */
// testbench: bus master, pin checks and peripheral stimulus for pgp_port3
// assumes hready follows hreadyout and the far-side model feeds pin_i
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pgp_pkg::*;
   logic        clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 39;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic        rd_vld = 0, pin_vld = 0, hbs = 1, sco = 0, sco_en = 0;
   logic        bdis = 0, wcfg = 1, hold = 0, rxo = 1, rxoe = 0, ain_vld = 0;
   logic [15:0] pin_i, pin_o, pin_oe, ext_en = 0, ext_val = 0;
   logic [5:0]  alt = 6'h3F; // idle peripherals rest high
   logic [63:0] rq[$], pq[$];
   logic [9:0]  aq[$];
   // alternate inputs packed as lines 13, 11, 9..4, 2, 0
   wire  [9:0]  ain;
   int          fails = 0, n_checks = 0;
   assign hready = hreadyout;
   initial forever #25 clk = ~clk;
   pgp_far_side i_far (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pin_i(pin_i));
   pgp_port3 i_dut (.*, .timer6_toggle_out(alt[0]), .timer3_toggle_out(alt[1]),
      .async_serial_tx(alt[2]), .sync_master_rx_slave_tx(alt[3]),
      .sync_master_tx_slave_rx(alt[4]), .sync_clock_out(alt[5]),
      .async_serial_rx_out(rxo), .async_serial_rx_oe(rxoe), .high_byte_write_strobe(hbs),
      .system_clock_out(sco), .system_clock_out_en(sco_en), .byte_strobe_disable(bdis),
      .write_strobe_config(wcfg), .bus_hold(hold), .compare_timer0_count_in(ain[0]),
      .capture_in(ain[1]), .timer3_updown_in(ain[2]), .timer4_count_in(ain[3]),
      .timer3_count_in(ain[4]), .timer2_count_in(ain[5]), .async_serial_rx(ain[8]),
      .sync_master_rx_slave_tx_in(ain[6]), .sync_master_tx_slave_rx_in(ain[7]),
      .sync_clock_in(ain[9]));
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmp_rd(logic [31:0] g, logic [63:0] e);
      n_checks++;
      if ((g & e[63:32]) !== (e[31:0] & e[63:32])) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g & e[63:32], e[31:0]);
      end
   endtask
   task automatic cmp_pin(logic [31:0] g, logic [63:0] e);
      n_checks++;
      if ((g & e[63:32]) !== (e[31:0] & e[63:32])) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g & e[63:32], e[31:0]);
      end
   endtask
   task automatic cmp_alt(logic [9:0] g, logic [9:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   always @(posedge clk) begin
      if (rd_vld && rq.size() > 0) cmp_rd(hrdata, rq.pop_front());
      if (pin_vld && pq.size() > 0) cmp_pin({pin_oe, pin_o}, pq.pop_front());
      if (ain_vld && aq.size() > 0) cmp_alt(ain, aq.pop_front());
   end
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 20);
      if (hready !== 1'b1) begin
         fails++;
         end_of_test();
      end
   endtask
   // for a read, d is the expected value and m the checked low bits
   task automatic bus(logic wr, logic [17:0] a, logic [31:0] d, logic [15:0] m);
      hsel <= 1;
      htrans <= PGP_HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {14'h0, a};
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      rd_vld <= !wr;
      if (!wr) rq.push_back({16'hFFFF, m, d});
      wait_rdy();
      rd_vld <= 0;
   endtask
   task automatic pchk(logic [31:0] e, logic [31:0] m);
      pq.push_back({m, e});
      pin_vld <= 1;
      @(posedge clk);
      pin_vld <= 0;
      @(posedge clk);
   endtask
   task automatic achk(logic [9:0] e);
      aq.push_back(e);
      ain_vld <= 1;
      @(posedge clk);
      ain_vld <= 0;
      @(posedge clk);
   endtask
   initial begin
      #2ms;
      fails++;
      end_of_test();
   end
   initial begin
      int i;
      logic [15:0] v;
      repeat (12) @(posedge clk);
      sys_rst <= 0;
      repeat (3) @(posedge clk);
      pchk(32'h1000_1000, 32'h1000_1000);
      bus(0, PGP_BYTE_STRAP, 1, 16'h0001);
      bus(0, PGP_BYTE_DIRECTION, 0, 16'hFFFF);
      bus(0, PGP_BYTE_OPEN_DRAIN, 0, 16'hFFFF);
      bdis <= 1;
      wcfg <= 0;
      repeat (2) @(posedge clk);
      pchk(0, 32'h1000_0000);
      bus(0, PGP_BYTE_STRAP, 0, 16'h0001);
      bus(0, 18'h00100, 0, 16'hFFFF);
      bus(1, PGP_BYTE_DIRECTION, 32'hFFFF, 0);
      bus(0, PGP_BYTE_DIRECTION, 32'hBFFF, 16'hFFFF);
      bus(1, PGP_BYTE_OPEN_DRAIN, 32'hFFFF, 0);
      bus(0, PGP_BYTE_OPEN_DRAIN, 32'h2FFF, 16'hFFFF);
      for (i = 0; i < 4; i++) begin
         v = rnd();
         bus(1, PGP_BYTE_DATA, {16'h0, v}, 0);
         bus(0, PGP_BYTE_DATA, {16'h0, v}, 16'hBFFF);
         pchk({16'hBFFF & ~(v & 16'h2FFF), v}, 32'hFFFF_BFFF);
      end
      bus(1, PGP_BYTE_OPEN_DRAIN, 0, 0);
      pchk({16'hBFFF, v}, 32'hFFFF_BFFF);
      bus(1, PGP_BYTE_DATA, 32'hFFFF, 0);
      for (i = 0; i < 4; i++) begin
         v = rnd();
         alt <= v[5:0];
         @(posedge clk);
         pchk({18'h0, v[5], 2'b0, v[2], v[4], v[3], 4'b0, v[1], 1'b0, v[0], 1'b0},
            32'h0000_270A);
      end
      alt <= 6'h3F;
      bus(1, PGP_BYTE_DIRECTION, 0, 0);
      ext_en <= 16'hFFFF;
      for (i = 0; i < 3; i++) begin
         v = rnd();
         ext_val <= v;
         repeat (3) @(posedge clk);
         achk({v[13], v[11], v[9:4], v[2], v[0]});
         bus(0, PGP_BYTE_DATA, {16'h0, v}, 16'hFFFF);
      end
      rxoe <= 1;
      rxo <= 0;
      repeat (2) @(posedge clk);
      pchk(32'h0800_0000, 32'h0800_0800);
      rxo <= 1;
      @(posedge clk);
      pchk(32'h0800_0800, 32'h0800_0800);
      rxoe <= 0;
      bdis <= 0;
      hbs <= 0;
      repeat (2) @(posedge clk);
      pchk(32'h1000_0000, 32'h1000_1000);
      hold <= 1;
      repeat (2) @(posedge clk);
      pchk(0, 32'h1000_0000);
      bus(1, PGP_BYTE_DIRECTION, 32'h1000, 0);
      bus(1, PGP_BYTE_DATA, 0, 0);
      pchk(32'h1000_0000, 32'h1000_1000);
      hold <= 0;
      sco_en <= 1;
      repeat (2) @(posedge clk);
      pchk(32'h8000_0000, 32'h8000_8000);
      sco <= 1;
      @(posedge clk);
      pchk(32'h8000_8000, 32'h8000_8000);
      end_of_test();
   end
endmodule
`default_nettype wire
